// ===== hw/sltx_pkg.sv
// sltx_pkg: constants, encodings and carrier types for the frame transmit port
// assumes: included first; shared by the design and by the bench
package sltx_pkg;
    // apb register byte offsets
    localparam logic [7:0] SLTX_REG_CTRL = 8'h00;
    localparam logic [7:0] SLTX_REG_STATUS = 8'h04;
    localparam logic [7:0] SLTX_REG_CELLS = 8'h08;
    localparam logic [7:0] SLTX_REG_OPS = 8'h0c;
    // ctrl field positions (write-one pulses)
    localparam int SLTX_CTRL_FLUSH_BIT = 0;
    localparam int SLTX_CTRL_RELINK_BIT = 1;
    // link words: low byte is the k character, high byte the payload byte
    localparam logic [15:0] SLTX_IDLE_WORD = 16'h00bc;
    localparam logic [15:0] SLTX_TRAIN_WORD = 16'h4a3c;
    localparam logic [7:0] SLTX_OP_MARK = 8'h7c;
    // training words sent after the phy reports ready, before going up
    localparam logic [7:0] SLTX_TRAIN_WORDS = 8'h10;
    // documented defaults
    localparam int SLTX_LANES_DEF = 4;
    localparam int SLTX_CELL_MSB_DEF = 7;
    localparam int SLTX_CHANS = 4;

    typedef enum logic [1:0] {
        SLTX_LK_DOWN,
        SLTX_LK_TRAIN,
        SLTX_LK_UP
    } sltx_link_t;

    typedef enum logic [1:0] {
        SLTX_CS_IDLE,
        SLTX_CS_HEAD,
        SLTX_CS_PAY,
        SLTX_CS_TAIL
    } sltx_cell_t;

    // per channel control and buffer status bits travelling with the data bus
    typedef struct packed {
        logic chan_word_valid;
        logic chan_frame_first;
        logic chan_frame_last;
        logic chan_frame_bad;
        logic chan_near_buf_nearly_full;
        logic chan_near_buf_full;
    } sltx_chan_t;
endpackage

// ===== hw/sltx_frame_port.sv
// sltx_frame_port: user side of a multi lane frame link transmitter
// assumes: one clock; tx_link_rst_in synchronous to it; apb master on the same clock
// Functional notes
// RULE1: user holds link reset two clocks, synchronously
// RULE2: link reset clears everything, restarts bring-up
// RULE3: flush drops frame state, link stays up
// RULE4: side up only after training, sending
// RULE5: opcode request stalls data one cycle
// RULE6: opcode pulses single, widely spaced
// RULE7: opcode captured on request, sent raw
// RULE8: near receiver status carried to far end
// RULE9: sideband byte captured per cell, sent raw
// RULE10: four independent channel ports
// RULE11: word moves when valid and ready
// RULE12: user marks first and last words
// RULE13: bad marker rides with last word
// RULE14: channel bus sixteen bits per lane
// RULE15: buffer status sent in every cell
// RULE16: user tolerates ready dropping anytime
// RULE17: valid may drop anytime, resume cleanly
// RULE18: never throttle on far buffer status
// RULE19: user watches far buffer status itself
// RULE20: lane count one to four only
// RULE21: cell length msb defaults to seven
// RULE22: ready low in reset or link down
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module sltx_frame_port #(
    parameter int LANES = sltx_pkg::SLTX_LANES_DEF,
    parameter int CELL_MSB = sltx_pkg::SLTX_CELL_MSB_DEF
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    input wire logic tx_link_rst_in,
    input wire logic tx_frame_state_clear_in,
    input wire logic phy_ready_in,
    input wire logic sideband_cmd_req_in,
    input wire logic [7:0] sideband_cmd_value_in,
    input wire logic near_rx_up_in,
    input wire logic [7:0] cell_sideband_byte_in,
    input wire sltx_pkg::sltx_chan_t [3:0] chan_ctl_in,
    input wire logic [3:0][LANES*16-1:0] chan_word_bus_in,
    output logic [3:0] chan_word_ready_out,
    output logic tx_side_up_out,
    output logic [LANES*16-1:0] link_word_out,
    output logic [LANES*2-1:0] link_word_k_out,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import sltx_pkg::*;

    localparam int W = LANES * 16;
    localparam int KW = LANES * 2;

    // RULE20: refuse lane counts the framing cannot serve
    // RULE21: cell counter must fit in sixteen bits
    if (LANES < 1 || LANES > 4) begin : g_bad_lanes
        $error("sltx_frame_port: LANES must be 1 to 4");
    end
    if (CELL_MSB < 1 || CELL_MSB > 14) begin : g_bad_msb
        $error("sltx_frame_port: CELL_MSB must be 1 to 14");
    end

    localparam logic [15:0] CELL_MAX = 16'((1 << (CELL_MSB + 1)) - 1);

    typedef struct packed {
        sltx_link_t lk;
        logic [7:0] train;
        sltx_cell_t cs;
        logic [1:0] vc;
        logic [1:0] rr;
        logic [15:0] pcnt;
        logic eof;
        logic bad;
        logic [7:0] sb;
        logic op_pend;
        logic [7:0] op_val;
        logic [W-1:0] word;
        logic [KW-1:0] wk;
        logic soft_flush;
        logic soft_relink;
        logic [31:0] cells;
        logic [31:0] ops;
        logic [31:0] rdata;
        logic slverr;
    } sltx_state_t;

    localparam sltx_state_t RESET_STATE = '{
        lk: SLTX_LK_DOWN,
        cs: SLTX_CS_IDLE,
        word: W'(SLTX_IDLE_WORD),
        wk: KW'(1),
        default: '0
    };

    // reset release through two flops; assertion stays asynchronous
    logic [1:0] rst_sync_q;
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    logic rst_n;
    assign rst_n = rst_sync_q[1];

    sltx_state_t q, d;
    logic flush;
    logic relink;
    logic stall_op;
    logic [1:0] pick;
    logic found;
    logic [15:0] head;

    // RULE1: the link reset is trusted to be synchronous and two clocks long
    assign relink = tx_link_rst_in | q.soft_relink;
    assign flush = tx_frame_state_clear_in | q.soft_flush;
    assign stall_op = q.op_pend;

    // RULE22: ready only while up, in payload, not stalled, not resetting
    // RULE18: far buffer status plays no part in ready
    generate
        for (genvar i = 0; i < SLTX_CHANS; i++) begin : g_ready
            // RULE10: each channel has its own ready
            assign chan_word_ready_out[i] = ce_in && rst_n && !relink && !flush
                && phy_ready_in && q.lk == SLTX_LK_UP && q.cs == SLTX_CS_PAY
                && q.vc == 2'(i) && !stall_op;
        end
    endgenerate

    // round robin from the channel after the last served one
    always_comb begin
        pick = q.rr;
        found = 1'b0;
        for (int i = SLTX_CHANS - 1; i >= 0; i--) begin
            if (chan_ctl_in[2'(q.rr + 2'(i))].chan_word_valid) begin
                pick = 2'(q.rr + 2'(i));
                found = 1'b1;
            end
        end
    end

    // RULE15: buffer status of all channels rides in every header
    // RULE8: near receiver state rides in every header
    always_comb begin
        head = {4'h0, q.vc, chan_ctl_in[q.vc].chan_frame_first, near_rx_up_in,
                chan_ctl_in[3].chan_near_buf_nearly_full,
                chan_ctl_in[2].chan_near_buf_nearly_full,
                chan_ctl_in[1].chan_near_buf_nearly_full,
                chan_ctl_in[0].chan_near_buf_nearly_full,
                chan_ctl_in[3].chan_near_buf_full,
                chan_ctl_in[2].chan_near_buf_full,
                chan_ctl_in[1].chan_near_buf_full,
                chan_ctl_in[0].chan_near_buf_full};
    end

    // next state: link bring-up, cell engine, opcode slot, apb
    always_comb begin
        d = q;
        d.soft_flush = 1'b0;
        d.soft_relink = 1'b0;
        d.word = W'(SLTX_IDLE_WORD);
        d.wk = KW'(1);
        // RULE4: train after phy ready, then declare the side up
        unique case (q.lk)
            SLTX_LK_DOWN: begin
                d.train = 8'h00;
                if (phy_ready_in) begin
                    d.lk = SLTX_LK_TRAIN;
                end
            end
            SLTX_LK_TRAIN: begin
                d.word = W'(SLTX_TRAIN_WORD);
                d.train = q.train + 8'h01;
                if (q.train == SLTX_TRAIN_WORDS - 8'h01) begin
                    d.lk = SLTX_LK_UP;
                end
            end
            SLTX_LK_UP: begin
                // RULE5: an opcode takes exactly one slot, data waits
                // RULE7: opcode sits outside the checked cell body
                if (q.op_pend) begin
                    d.word = W'({q.op_val, SLTX_OP_MARK});
                    d.op_pend = 1'b0;
                    d.ops = q.ops + 32'h1;
                end else begin
                    unique case (q.cs)
                        SLTX_CS_IDLE: begin
                            if (found) begin
                                d.vc = pick;
                                d.cs = SLTX_CS_HEAD;
                            end
                        end
                        SLTX_CS_HEAD: begin
                            // RULE9: sideband byte captured as the cell forms
                            d.sb = cell_sideband_byte_in;
                            d.word = W'(head);
                            d.wk = '0;
                            d.pcnt = 16'h0000;
                            d.eof = 1'b0;
                            d.bad = 1'b0;
                            d.cs = SLTX_CS_PAY;
                        end
                        SLTX_CS_PAY: begin
                            // RULE11: a word moves only when valid meets ready
                            // RULE17: a valid gap closes the cell, frame resumes later
                            if (chan_ctl_in[q.vc].chan_word_valid) begin
                                d.word = chan_word_bus_in[q.vc];
                                d.wk = '0;
                                d.pcnt = q.pcnt + 16'h0001;
                                // RULE13: bad marker only counts with the last word
                                if (chan_ctl_in[q.vc].chan_frame_last) begin
                                    d.eof = 1'b1;
                                    d.bad = chan_ctl_in[q.vc].chan_frame_bad;
                                    d.cs = SLTX_CS_TAIL;
                                end else if (q.pcnt == CELL_MAX - 16'h0001) begin
                                    d.cs = SLTX_CS_TAIL;
                                end
                            end else begin
                                d.cs = SLTX_CS_TAIL;
                            end
                        end
                        SLTX_CS_TAIL: begin
                            d.word = W'({q.eof, q.bad, 6'h00, q.sb});
                            d.wk = '0;
                            d.rr = q.vc + 2'h1;
                            d.cells = q.cells + 32'h1;
                            d.cs = SLTX_CS_IDLE;
                        end
                    endcase
                end
            end
            default: d.lk = SLTX_LK_DOWN;
        endcase
        // losing the phy drops the cell and retrains
        if (!phy_ready_in) begin
            d.lk = SLTX_LK_DOWN;
            d.cs = SLTX_CS_IDLE;
            d.op_pend = 1'b0;
            d.word = W'(SLTX_IDLE_WORD);
            d.wk = KW'(1);
        end
        // RULE3: frame state cleared, link state untouched
        if (flush) begin
            d.cs = SLTX_CS_IDLE;
            // RULE11: refused word stays off link
            if (q.cs == SLTX_CS_PAY && !q.op_pend) begin
                d.word = W'(SLTX_IDLE_WORD);
                d.wk = KW'(1);
            end
            d.pcnt = 16'h0000;
            d.eof = 1'b0;
            d.bad = 1'b0;
        end
        // RULE7: capture value with the request; set placed after the clears so it wins, only link reset overrides it
        if (sideband_cmd_req_in && q.lk == SLTX_LK_UP && phy_ready_in) begin
            d.op_pend = 1'b1;
            d.op_val = sideband_cmd_value_in;
        end
        // apb: read data latched in setup, writes act in the access cycle
        if (psel && !penable) begin
            d.slverr = 1'b0;
            unique case (paddr)
                SLTX_REG_CTRL: d.rdata = 32'h0;
                SLTX_REG_STATUS: d.rdata = {25'h0, q.cs, q.vc, q.op_pend,
                                            phy_ready_in, q.lk == SLTX_LK_UP};
                SLTX_REG_CELLS: d.rdata = q.cells;
                SLTX_REG_OPS: d.rdata = q.ops;
                default: begin
                    d.rdata = 32'h0;
                    d.slverr = 1'b1;
                end
            endcase
        end
        if (psel && penable && pwrite && paddr == SLTX_REG_CTRL) begin
            d.soft_flush = pwdata[SLTX_CTRL_FLUSH_BIT];
            d.soft_relink = pwdata[SLTX_CTRL_RELINK_BIT];
        end
        // RULE2: link reset returns every element to its start value
        if (relink) begin
            d = RESET_STATE;
        end
    end

    // single state register, frozen while the clock enable is low
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            q <= RESET_STATE;
        end else if (ce_in) begin
            q <= d;
        end
    end

    // RULE14: link word is sixteen bits per lane, straight from flops
    assign link_word_out = q.word;
    assign link_word_k_out = q.wk;
    assign tx_side_up_out = q.lk == SLTX_LK_UP;
    assign prdata = q.rdata;
    assign pready = 1'b1;           // zero wait states keep the slave simple
    assign pslverr = psel & penable & q.slverr;
endmodule

// ===== bench/sltx_frame_chk_checker.sv
// sltx_frame_chk: concurrent checks on the frame transmit port
// assumes: bound into sltx_frame_port; one clock, async active-low reset
`timescale 1ns/10ps
module sltx_frame_chk #(
    parameter int LANES = 1
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    input wire logic tx_link_rst_in,
    input wire logic tx_frame_state_clear_in,
    input wire logic phy_ready_in,
    input wire logic sideband_cmd_req_in,
    input wire logic [7:0] sideband_cmd_value_in,
    input wire sltx_pkg::sltx_chan_t [3:0] chan_ctl_in,
    input wire logic [3:0][LANES*16-1:0] chan_word_bus_in,
    input wire logic [3:0] chan_word_ready_out,
    input wire logic tx_side_up_out,
    input wire logic [LANES*16-1:0] link_word_out,
    input wire logic [LANES*2-1:0] link_word_k_out
);
    import sltx_pkg::*;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    property p_rdy_down; tx_link_rst_in || !tx_side_up_out |-> chan_word_ready_out == 4'h0; endproperty
    a_rdy_down: assert property (p_rdy_down) else $error("ready while down");
    property p_one; $onehot0(chan_word_ready_out); endproperty
    a_one: assert property (p_one) else $error("two channels ready");
    // a taken word shows up unchanged one edge later, as data not k
    property p_pass(int c);
        chan_word_ready_out[c] && chan_ctl_in[c].chan_word_valid && ce_in
            |=> link_word_out == $past(chan_word_bus_in[c]) && link_word_k_out == '0;
    endproperty
    for (genvar c = 0; c < 4; c++) begin : g_pass
        a_pass: assert property (p_pass(c)) else $error("word lost");
    end
    property p_op;
        sideband_cmd_req_in && tx_side_up_out && phy_ready_in && ce_in && !tx_link_rst_in
            |=> chan_word_ready_out == 4'h0 ##1
            link_word_out[15:0] == {$past(sideband_cmd_value_in, 2), SLTX_OP_MARK};
    endproperty
    a_op: assert property (p_op) else $error("opcode slot wrong");
    property p_flush;
        tx_frame_state_clear_in && tx_side_up_out && phy_ready_in && ce_in && !tx_link_rst_in
            |-> chan_word_ready_out == 4'h0 ##1 tx_side_up_out;
    endproperty
    a_flush: assert property (p_flush) else $error("flush dropped link");
    property p_rst;
        tx_link_rst_in && ce_in |=> !tx_side_up_out && link_word_out[15:0] == SLTX_IDLE_WORD;
    endproperty
    a_rst: assert property (p_rst) else $error("link reset ignored");
    // up needs phy ready sixteen cycles back and a training word two cycles back
    property p_up;
        $rose(tx_side_up_out) |-> $past(phy_ready_in, 16) &&
            $past(link_word_out[15:0], 2) == SLTX_TRAIN_WORD;
    endproperty
    a_up: assert property (p_up) else $error("up too early");
    property p_phy; !phy_ready_in |-> chan_word_ready_out == 4'h0 ##1 !tx_side_up_out; endproperty
    a_phy: assert property (p_phy) else $error("up without phy");
    c_pass: cover property (chan_word_ready_out[0] && chan_ctl_in[0].chan_word_valid);
    c_op: cover property (sideband_cmd_req_in && tx_side_up_out);
    c_flush: cover property (tx_frame_state_clear_in && tx_side_up_out);
endmodule
bind sltx_frame_port sltx_frame_chk #(.LANES(LANES)) u_chk (.clk_sys_in, .reset_n_in, .ce_in,
    .tx_link_rst_in, .tx_frame_state_clear_in, .phy_ready_in, .sideband_cmd_req_in,
    .sideband_cmd_value_in, .chan_ctl_in, .chan_word_bus_in, .chan_word_ready_out,
    .tx_side_up_out, .link_word_out, .link_word_k_out);

// ===== bench/sltx_user_model.sv
// sltx_user_model: user logic feeding one frame at a time into a channel
// assumes: bench sets chan/len/slow then pulses go; odd channels end bad
`timescale 1ns/10ps
module sltx_user_model #(
    parameter logic [7:0] STAT = 8'h5a
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic go_in,
    input wire logic slow_in,
    input wire logic [1:0] chan_in,
    input wire logic [7:0] len_in,
    input wire logic [3:0] ready_in,
    output sltx_pkg::sltx_chan_t [3:0] ctl_out,
    output logic [3:0][15:0] bus_out,
    output logic [7:0] sent_out,
    output logic busy_out
);
    import sltx_pkg::*;
    logic ph_q;
    logic vld;
    // slow mode leaves a hole in valid every other cycle
    assign vld = busy_out && (!slow_in || ph_q);
    // count on valid and ready only
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            busy_out <= 1'b0;
            sent_out <= 8'h00;
        end else if (go_in) begin
            busy_out <= 1'b1;
            sent_out <= 8'h00;
        end else if (vld && ready_in[chan_in]) begin
            sent_out <= sent_out + 8'h01;
            busy_out <= sent_out + 8'h01 != len_in;
        end
    end
    // gap phase toggles every cycle out of reset
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ph_q <= 1'b0;
        end else begin
            ph_q <= ~ph_q;
        end
    end
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            ctl_out[c] = {4'h0, STAT[4+c], STAT[c]};
            bus_out[c] = ~{6'h00, c[1:0], sent_out};
            if (c == chan_in && vld) begin
                ctl_out[c] = {1'b1, sent_out == 8'h00, sent_out + 8'h01 == len_in,
                    sent_out + 8'h01 == len_in && chan_in[0], STAT[4+c], STAT[c]};
                bus_out[c] = {6'h00, c[1:0], sent_out};
            end
        end
    end
endmodule

// ===== bench/testbench.sv
// testbench: frames, opcode, flush, link reset and apb on one port
// assumes: package, user model and checker compiled first
`timescale 1ns/10ps
module testbench;
    import sltx_pkg::*;
    logic clk_sys_in = 1'b0, reset_n_in = 1'b0, ce_in = 1'b1, lrst = 1'b0, flush = 1'b0;
    logic phy = 1'b0, req = 1'b0, go = 1'b0, slow = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pk = 1'b1, nup = 1'b0, pready, pslverr, busy, up, err;
    logic [7:0] opv = 8'h00, sb = 8'h00, paddr = 8'h00, len = 8'h01, sent;
    logic [1:0] chan = 2'd0, lk;
    logic [3:0] rdy;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] lw, pw, tail, opw, hd;
    sltx_chan_t [3:0] ctl;
    logic [3:0][15:0] bus;
    int failures = 0;
    int n_checks = 0;
    sltx_frame_port #(.LANES(1)) uut (.clk_sys_in, .reset_n_in, .ce_in,
        .tx_link_rst_in(lrst), .tx_frame_state_clear_in(flush), .phy_ready_in(phy),
        .sideband_cmd_req_in(req), .sideband_cmd_value_in(opv), .near_rx_up_in(nup),
        .cell_sideband_byte_in(sb), .chan_ctl_in(ctl), .chan_word_bus_in(bus),
        .chan_word_ready_out(rdy), .tx_side_up_out(up), .link_word_out(lw),
        .link_word_k_out(lk), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);
    sltx_user_model u_user (.clk_sys_in, .reset_n_in, .go_in(go), .slow_in(slow),
        .chan_in(chan), .len_in(len), .ready_in(rdy), .ctl_out(ctl), .bus_out(bus),
        .sent_out(sent), .busy_out(busy));
    // 250 MHz clock
    initial begin
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    // keep the last cell word before idle, and any opcode word
    always @(posedge clk_sys_in) begin
        if (!pk && lk[0] && lw == SLTX_IDLE_WORD) tail <= pw;
        if (lk[0] && lw[7:0] == SLTX_OP_MARK) opw <= lw;
        // header is the first data word after an idle word
        if (pk && !lk[0] && pw == SLTX_IDLE_WORD) hd <= lw;
        pw <= lw;
        pk <= lk[0];
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wait_up();
        for (int i = 0; i < 40 && up !== 1'b1; i++) @(posedge clk_sys_in);
        chk(up, 1'b1);
    endtask
    // pulse opcode or flush ten cycles into a frame
    task automatic poke(input logic o, input logic f);
        repeat (10) @(posedge clk_sys_in);
        opv <= 8'h5a;
        req <= o;
        flush <= f;
        @(posedge clk_sys_in);
        req <= 1'b0;
        flush <= 1'b0;
    endtask
    task automatic send(input logic [1:0] c, input logic [7:0] n, input logic s);
        chan <= c;
        len <= n;
        slow <= s;
        sb <= {6'h2a, c};
        nup <= c[1];
        go <= 1'b1;
        @(posedge clk_sys_in);
        go <= 1'b0;
        @(posedge clk_sys_in);
        for (int i = 0; i < 300 && busy; i++) @(posedge clk_sys_in);
        repeat (6) @(posedge clk_sys_in);
        chk(sent, n);
        chk(tail, {1'b1, c[0], 6'h00, 6'h2a, c});
        chk({hd[15:10], hd[8:0]}, {4'h0, c, c[1], 8'h5a});
    endtask
    // idle cycle, setup, then access until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_in);
        penable <= 1'b1;
        @(posedge clk_sys_in);
        while (pready !== 1'b1) @(posedge clk_sys_in);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        phy <= 1'b1;
        wait_up();
        for (int c = 0; c < 4; c++) send(2'(c), 8'd3, 1'b0);
        send(2'd1, 8'd5, 1'b1);
        fork
            send(2'd0, 8'd20, 1'b0);
            begin
                repeat (8) @(posedge clk_sys_in);
                ce_in <= 1'b0;
                repeat (3) @(posedge clk_sys_in);
                ce_in <= 1'b1;
            end
        join
        $display("test frames done");
        fork
            send(2'd2, 8'd40, 1'b0);
            poke(1'b1, 1'b0);
        join
        chk(opw, {8'h5a, SLTX_OP_MARK});
        fork
            send(2'd3, 8'd30, 1'b0);
            poke(1'b0, 1'b1);
        join
        chk(up, 1'b1);
        $display("test opcode and flush done");
        lrst <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        lrst <= 1'b0;
        @(negedge clk_sys_in);
        chk({up, rdy}, 5'h00);
        wait_up();
        apb(1'b0, SLTX_REG_STATUS, 32'h0);
        chk(rd[1:0], 2'b11);
        send(2'd0, 8'd3, 1'b0);
        apb(1'b0, SLTX_REG_CELLS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, SLTX_REG_OPS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, SLTX_REG_CTRL, 32'h1);
        apb(1'b1, SLTX_REG_CTRL, 32'h2);
        @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk(up, 1'b0);
        wait_up();
        phy <= 1'b0;
        @(posedge clk_sys_in);
        phy <= 1'b1;
        @(negedge clk_sys_in);
        chk({up, rdy}, 5'h00);
        wait_up();
        apb(1'b0, 8'h10, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        $display("test reset and registers done");
        stop_test();
    end
    // hang guard, well past the expected run length
    initial begin
        #40000;
        failures++;
        stop_test();
    end
endmodule
